// ===== pkg/lasm_pkg.sv
// Package: register map, field positions and reset values of the alarm block
package lasm_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] ALARM_SUMMARY_ADDR = 12'h2c0;
  localparam logic [11:0] EVENT_FLAG_ADDR = 12'h2c1;
  localparam logic [11:0] EVENT_BLOCK_ADDR = 12'h2c2;
  localparam logic [11:0] LANE_ERR_ADDR = 12'h2c4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FIFO_BIT = 5;
  localparam int PLL_BIT = 4;
  localparam int LINK_BIT = 3;
  localparam int REALIGN_BIT = 2;
  localparam int RSVD1_BIT = 1;
  localparam int DIVIDER_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [7:0] EVENT_FLAG_RST = 8'h3f;
  localparam logic [7:0] EVENT_BLOCK_RST = 8'h3f;
  localparam logic [7:0] LANE_ERR_RST = 8'hff;
  localparam logic [7:0] FLAG_ACTIVE_MASK = 8'h3d;

endpackage : lasm_pkg

// ===== hdl/lasm_alarm.sv
// Alarm flags, alarm masks, per-lane FIFO errors and summary alarm
// ------------------------------------------------------------------
// How it works
// - Any active lane FIFO overflow or underflow sets status bit 5.
// - Status flags are sticky; writing one clears, writing zero keeps.
// - Serdes PLL not locked sets status bit 4.
// - 8B/10B: link enabled but outside payload state sets bit 3.
// - 64B/66B: link startup or any realignment event sets bit 3.
// - SYSREF realignment of internal clocks sets status bit 2.
// - Divider mismatch between channel pairs AB and CD sets bit 0.
// - Reset loads every flag with one, status reads 0x3f.
// - Mask bits 5,4,3,2,0 block flags from summary; reset 0x3f.
// - Per-lane error bit i sets on active lane i FIFO overflow or underflow.
// - Writing one clears a lane bit; persisting condition resets it.
// - Writing one to status bit 5 clears all lane error bits.
// - Reset loads the per-lane error register with 0xff.
// - Summary bit high when any unmasked flag set; routable to pin.
// ------------------------------------------------------------------
module lasm_alarm
  import lasm_pkg::*;
#(
  parameter int LANES = 8
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Soft reset from the control registers, same clock
  input wire logic soft_reset_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Link state, same clock
  input wire logic serial_link_enable_i,
  input wire logic enc_64b66b_i,
  input wire logic payload_state_i,
  input wire logic link_startup_i,
  input wire logic realign_event_i,
  input wire logic sysref_realign_i,
  input wire logic serdes_pll_locked_i,
  input wire logic [LANES-1:0] lane_active_i,
  input wire logic [LANES-1:0] lane_fifo_err_i,
  // Clock divider phases of channel pairs
  input wire logic [3:0] div_ab_i,
  input wire logic [3:0] div_cd_i,
  // Summary alarm routing
  input wire logic cal_status_sel_alarm_i,
  input wire logic cal_status_i,
  output logic alarm_o,
  output logic calibration_state_output_o
);

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  logic [7:0] event_flag_register_r;
  logic [7:0] event_block_register_r;
  logic [LANES-1:0] per_lane_fifo_error_r;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [LANES-1:0] lane_set;
  logic [LANES-1:0] lane_clr;
  logic link_not_up;
  logic wr_flag;
  logic wr_block;
  logic wr_lane;
  logic summary;
  logic [7:0] rdata_nxt;

  assign wr_flag = reg_wr_i && (reg_addr_i == EVENT_FLAG_ADDR);
  assign wr_block = reg_wr_i && (reg_addr_i == EVENT_BLOCK_ADDR);
  assign wr_lane = reg_wr_i && (reg_addr_i == LANE_ERR_ADDR);

  // Per-lane error events
  assign lane_set = lane_fifo_err_i & lane_active_i;

  // Link flag cause depends on encoding
  always_comb begin
    if (enc_64b66b_i) begin
      link_not_up = link_startup_i || realign_event_i;
    end else begin
      link_not_up = serial_link_enable_i && !payload_state_i;
    end
  end

  // Set vector for the status flags
  always_comb begin
    set_vec = 8'h00;
    set_vec[FIFO_BIT] = |lane_set;
    set_vec[PLL_BIT] = !serdes_pll_locked_i;
    set_vec[LINK_BIT] = link_not_up;
    set_vec[REALIGN_BIT] = sysref_realign_i;
    set_vec[DIVIDER_BIT] = (div_ab_i != div_cd_i);
  end

  // Write-one-to-clear vectors
  assign clr_vec = wr_flag ? (reg_wdata_i & FLAG_ACTIVE_MASK) : 8'h00;
  always_comb begin
    lane_clr = '0;
    if (wr_lane) begin
      lane_clr = reg_wdata_i[LANES-1:0];
    end
    if (wr_flag && reg_wdata_i[FIFO_BIT]) begin
      lane_clr = '1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Sticky status flags; bit 1 is reserved and holds its reset value
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || soft_reset_i) begin
      event_flag_register_r <= EVENT_FLAG_RST;
    end else begin
      event_flag_register_r <= ((event_flag_register_r & ~clr_vec) | set_vec)
                               & EVENT_FLAG_RST;
    end
  end

  // Mask register, plain read/write
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || soft_reset_i) begin
      event_block_register_r <= EVENT_BLOCK_RST;
    end else if (wr_block) begin
      event_block_register_r <= reg_wdata_i;
    end
  end

  // Per-lane sticky errors
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || soft_reset_i) begin
      per_lane_fifo_error_r <= LANE_ERR_RST[LANES-1:0];
    end else begin
      per_lane_fifo_error_r <= (per_lane_fifo_error_r & ~lane_clr) | lane_set;
    end
  end

  // ----------------------------------------------------------------
  // Summary alarm and read data
  // ----------------------------------------------------------------
  assign summary = |(event_flag_register_r & ~event_block_register_r & FLAG_ACTIVE_MASK);

  // Summary bit and pin routing
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || soft_reset_i) begin
      alarm_o <= 1'b0;
      calibration_state_output_o <= 1'b0;
    end else begin
      alarm_o <= summary;
      calibration_state_output_o <= cal_status_sel_alarm_i ? summary : cal_status_i;
    end
  end

  // Read multiplexer
  always_comb begin
    rdata_nxt = 8'h00;
    case (reg_addr_i)
      ALARM_SUMMARY_ADDR: rdata_nxt = {7'h00, summary};
      EVENT_FLAG_ADDR: rdata_nxt = event_flag_register_r;
      EVENT_BLOCK_ADDR: rdata_nxt = event_block_register_r;
      LANE_ERR_ADDR: rdata_nxt[LANES-1:0] = per_lane_fifo_error_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Registered read data
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_reset_flags;
    @(posedge ref_clk_i) !rst_b_i |=> (event_flag_register_r == EVENT_FLAG_RST)
      && (per_lane_fifo_error_r == LANE_ERR_RST[LANES-1:0]);
  endproperty
  a_reset_flags: assert property (p_reset_flags)
    else $error("flags not at reset value after reset");

  property p_w1c_clears;
    @(posedge ref_clk_i) disable iff (!rst_b_i || soft_reset_i)
      (wr_flag && reg_wdata_i[PLL_BIT] && serdes_pll_locked_i)
      |=> !event_flag_register_r[PLL_BIT];
  endproperty
  a_w1c_clears: assert property (p_w1c_clears)
    else $error("write one did not clear pll flag");

  property p_zero_keeps;
    @(posedge ref_clk_i) disable iff (!rst_b_i || soft_reset_i)
      (event_flag_register_r[REALIGN_BIT] && !(wr_flag && reg_wdata_i[REALIGN_BIT]))
      |=> event_flag_register_r[REALIGN_BIT];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("realign flag lost without a clear");

  property p_set_wins;
    @(posedge ref_clk_i) disable iff (!rst_b_i || soft_reset_i)
      (!serdes_pll_locked_i && wr_flag) |=> event_flag_register_r[PLL_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("pll unlock lost against clear");

  property p_divider;
    @(posedge ref_clk_i) disable iff (!rst_b_i || soft_reset_i)
      (div_ab_i != div_cd_i) |=> event_flag_register_r[DIVIDER_BIT];
  endproperty
  a_divider: assert property (p_divider)
    else $error("divider mismatch not flagged");

  property p_link_8b;
    @(posedge ref_clk_i) disable iff (!rst_b_i || soft_reset_i)
      (!enc_64b66b_i && serial_link_enable_i && !payload_state_i)
      |=> event_flag_register_r[LINK_BIT];
  endproperty
  a_link_8b: assert property (p_link_8b)
    else $error("link flag not set outside payload state");

  property p_fifo_clear_lanes;
    @(posedge ref_clk_i) disable iff (!rst_b_i || soft_reset_i)
      (wr_flag && reg_wdata_i[FIFO_BIT] && lane_set == '0)
      |=> (per_lane_fifo_error_r == '0) && !event_flag_register_r[FIFO_BIT];
  endproperty
  a_fifo_clear_lanes: assert property (p_fifo_clear_lanes)
    else $error("fifo flag clear did not clear lanes");

  property p_lane_sets;
    @(posedge ref_clk_i) disable iff (!rst_b_i || soft_reset_i)
      (lane_set != '0) |=> event_flag_register_r[FIFO_BIT]
      && ((per_lane_fifo_error_r & $past(lane_set)) == $past(lane_set));
  endproperty
  a_lane_sets: assert property (p_lane_sets)
    else $error("lane error not recorded");

  property p_summary;
    @(posedge ref_clk_i) disable iff (!rst_b_i || soft_reset_i)
      1'b1 |=> alarm_o == $past(|(event_flag_register_r & ~event_block_register_r
      & FLAG_ACTIVE_MASK));
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary alarm wrong");

  property p_link_64b;
    @(posedge ref_clk_i) disable iff (!rst_b_i || soft_reset_i)
      (enc_64b66b_i && (link_startup_i || realign_event_i))
      |=> event_flag_register_r[LINK_BIT];
  endproperty
  a_link_64b: assert property (p_link_64b)
    else $error("link flag not set on startup or realignment");

  property p_realign;
    @(posedge ref_clk_i) disable iff (!rst_b_i || soft_reset_i)
      sysref_realign_i |=> event_flag_register_r[REALIGN_BIT];
  endproperty
  a_realign: assert property (p_realign)
    else $error("clock realignment not flagged");

  property p_lane_clear;
    @(posedge ref_clk_i) disable iff (!rst_b_i || soft_reset_i)
      (wr_lane && lane_set == '0)
      |=> (per_lane_fifo_error_r & $past(reg_wdata_i[LANES-1:0])) == '0;
  endproperty
  a_lane_clear: assert property (p_lane_clear)
    else $error("lane error bit not cleared by write one");

  property p_mask_write;
    @(posedge ref_clk_i) disable iff (!rst_b_i || soft_reset_i)
      wr_block |=> event_block_register_r == $past(reg_wdata_i);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask register did not take written value");

  property p_soft_reset;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      soft_reset_i |=> (event_flag_register_r == EVENT_FLAG_RST)
      && (event_block_register_r == EVENT_BLOCK_RST)
      && (per_lane_fifo_error_r == LANE_ERR_RST[LANES-1:0]) && !alarm_o;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset did not restore alarm state");

  property p_read_flags;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (reg_addr_i == EVENT_FLAG_ADDR) |=> reg_rdata_o == $past(event_flag_register_r);
  endproperty
  a_read_flags: assert property (p_read_flags)
    else $error("status read data wrong");

  property p_pin_route;
    @(posedge ref_clk_i) disable iff (!rst_b_i || soft_reset_i)
      1'b1 |=> calibration_state_output_o == ($past(cal_status_sel_alarm_i)
      ? $past(|(event_flag_register_r & ~event_block_register_r & FLAG_ACTIVE_MASK))
      : $past(cal_status_i));
  endproperty
  a_pin_route: assert property (p_pin_route)
    else $error("calibration status pin routed wrong");

endmodule : lasm_alarm

// ===== test/test_lasm_alarm.sv
// Self-checking testbench of the alarm flag, mask and lane error block
module test_lasm_alarm
  import lasm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------------------------------
  logic ref_clk, rst_b, srst, wr, locked, en, enc, pay, start, rlgn, sys, sel, cst, alarm, pin;
  logic [11:0] addr;
  logic [7:0] wd, rd, act, lerr;
  logic [3:0] dcd;
  int fails = 0;
  int checks_done = 0;

  // Row: lane errors, {unlock,no payload,64b66b,startup,realign,sysref,mismatch}, flags, lanes
  typedef struct packed {logic [7:0] le; logic [6:0] c; logic [7:0] ef; logic [7:0] el;} lasm_row_t;
  localparam lasm_row_t ROWS [8] = '{'{8'h04, 7'h00, 8'h22, 8'h04}, '{8'h81, 7'h00, 8'h22, 8'h81},
    '{8'h00, 7'h40, 8'h12, 8'h00}, '{8'h00, 7'h20, 8'h0a, 8'h00}, '{8'h00, 7'h18, 8'h0a, 8'h00},
    '{8'h00, 7'h14, 8'h0a, 8'h00}, '{8'h00, 7'h02, 8'h06, 8'h00}, '{8'h00, 7'h01, 8'h03, 8'h00}};

  // Device under test
  lasm_alarm #(.LANES(8)) i_lasm_alarm (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .soft_reset_i(srst),
    .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rd),
    .serial_link_enable_i(en), .enc_64b66b_i(enc), .payload_state_i(pay),
    .link_startup_i(start), .realign_event_i(rlgn), .sysref_realign_i(sys),
    .serdes_pll_locked_i(locked), .lane_active_i(act), .lane_fifo_err_i(lerr),
    .div_ab_i(4'h0), .div_cd_i(dcd), .cal_status_sel_alarm_i(sel), .cal_status_i(cst),
    .alarm_o(alarm), .calibration_state_output_o(pin));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk) {wr, addr, wd} <= {1'b1, a, d};
    @(posedge ref_clk) wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge ref_clk) addr <= a;
    @(posedge ref_clk);
    @(negedge ref_clk) chk(rd, exp, "read data");
  endtask : rd_chk

  // Apply one cycle of alarm causes, then return to a quiet link
  task automatic pulse(input logic [6:0] c, input logic [7:0] le);
    @(posedge ref_clk) {locked, pay} <= ~c[6:5];
    {enc, start, rlgn, sys, lerr} <= {c[4:1], le};
    dcd <= c[0] ? 4'h5 : 4'h0;
    @(posedge ref_clk) {locked, pay, enc, start, rlgn, sys, dcd, lerr} <= {6'h30, 4'h0, 8'h00};
  endtask : pulse

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  // Clock generator
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Watchdog against a hung sequence
  initial begin
    repeat (3000) @(posedge ref_clk);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_b, srst, wr, locked, en, enc, pay, start, rlgn, sys, sel, cst} = 12'h1a0;
    {addr, wd, act, lerr, dcd} = {12'h000, 8'h00, 8'hff, 8'h00, 4'h0};
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd_chk(EVENT_FLAG_ADDR, 8'h3f);
    rd_chk(EVENT_BLOCK_ADDR, 8'h3f);
    rd_chk(LANE_ERR_ADDR, 8'hff);
    rd_chk(ALARM_SUMMARY_ADDR, 8'h00);
    chk(alarm, 1'b0, "alarm after reset");
    $display("test reset done");
    foreach (ROWS[i]) begin
      wr_reg(EVENT_FLAG_ADDR, 8'h3f);
      wr_reg(LANE_ERR_ADDR, 8'hff);
      pulse(ROWS[i].c, ROWS[i].le);
      rd_chk(EVENT_FLAG_ADDR, ROWS[i].ef);
      rd_chk(LANE_ERR_ADDR, ROWS[i].el);
    end
    $display("test cause rows done");
    wr_reg(EVENT_FLAG_ADDR, 8'h3f);
    pulse(7'h40, 8'h00);
    wr_reg(EVENT_FLAG_ADDR, 8'h00);
    rd_chk(EVENT_FLAG_ADDR, 8'h12);
    @(posedge ref_clk) locked <= 1'b0;
    wr_reg(EVENT_FLAG_ADDR, 8'h10);
    rd_chk(EVENT_FLAG_ADDR, 8'h12);
    wr_reg(EVENT_BLOCK_ADDR, 8'h2e);
    rd_chk(EVENT_BLOCK_ADDR, 8'h2e);
    rd_chk(ALARM_SUMMARY_ADDR, 8'h01);
    chk(alarm, 1'b1, "unmasked alarm");
    @(posedge ref_clk) sel <= 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk) chk(pin, 1'b1, "routed alarm pin");
    @(posedge ref_clk) locked <= 1'b1;
    wr_reg(EVENT_FLAG_ADDR, 8'h10);
    pulse(7'h02, 8'h00);
    rd_chk(EVENT_FLAG_ADDR, 8'h06);
    rd_chk(ALARM_SUMMARY_ADDR, 8'h00);
    chk({alarm, pin}, 2'b00, "masked alarm and pin");
    @(posedge ref_clk) sel <= 1'b0;
    cst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk) chk(pin, 1'b1, "calibration status passed to pin");
    $display("test mask and summary done");
    @(posedge ref_clk) lerr <= 8'h02;
    wr_reg(LANE_ERR_ADDR, 8'h02);
    rd_chk(LANE_ERR_ADDR, 8'h02);
    @(posedge ref_clk) lerr <= 8'h00;
    wr_reg(LANE_ERR_ADDR, 8'h02);
    rd_chk(LANE_ERR_ADDR, 8'h00);
    pulse(7'h00, 8'h0c);
    wr_reg(EVENT_FLAG_ADDR, 8'h20);
    rd_chk(LANE_ERR_ADDR, 8'h00);
    wr_reg(ALARM_SUMMARY_ADDR, 8'hff);
    rd_chk(ALARM_SUMMARY_ADDR, 8'h00);
    rd_chk(12'h2c3, 8'h00);
    @(posedge ref_clk) act <= 8'hfe;
    pulse(7'h00, 8'h01);
    rd_chk(LANE_ERR_ADDR, 8'h00);
    rd_chk(EVENT_FLAG_ADDR, 8'h06);
    @(posedge ref_clk) act <= 8'hff;
    $display("test lane errors done");
    @(posedge ref_clk) srst <= 1'b1;
    @(posedge ref_clk) srst <= 1'b0;
    rd_chk(EVENT_FLAG_ADDR, 8'h3f);
    rd_chk(EVENT_BLOCK_ADDR, 8'h3f);
    rd_chk(LANE_ERR_ADDR, 8'hff);
    $display("test soft reset done");
    summarize();
  end
endmodule : test_lasm_alarm
